/* bench/dpr_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpr_bus_model (
  input  wire logic        mclk_in,
  input  wire logic        load_n_in,
  input  wire logic        shift_clk_in,
  input  wire logic [15:0] word_in,
  input  wire logic        cycle_start_in,
  output logic             data_out,
  output logic             cycle_done_out
);
  logic [15:0] word_q;
  logic        start_seen;
  // load follows the word while reset is low, shift on each program clock rise
  always @(posedge shift_clk_in or negedge load_n_in or word_in) begin
    if (!load_n_in) begin
      word_q <= word_in;
    end else if (shift_clk_in) begin
      word_q <= {~word_q[0], word_q[15:1]};
    end
  end
  assign data_out = word_q[0];
  // ram cycle ends one clock after it starts
  always @(negedge mclk_in) begin
    start_seen <= cycle_start_in;
  end
  always @(posedge mclk_in) begin
    #2 cycle_done_out = start_seen;
  end
endmodule // dpr_bus_model
`default_nettype wire

/* bench/dpr_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dpr_ctrl_test;
  typedef struct packed {
    logic        use_strap;
    logic [15:0] word;
    logic [1:0]  port_control;
    logic [15:0] exp_word;
  } dpr_row_t;
  logic        mclk_in, rstn_in, refresh_in, strap_en, strap_lvl, sr_data, done_in, clr_cnt;
  logic [15:0] load_word;
  logic [1:0]  port_req_in, port_control_in, port_sync, port_iface, cycle_port, port_en_n;
  logic        pclk, prog_done, ecc, cycle_speed_select, clock_frequency_select, ram_speed_select, cycle_lengthen, busy, start, scrub, pclk_prev;
  logic [15:0] cfg_seen;
  int          fails, compares, pclk_rises, ref_starts, scrubs, lat, lat2;
  dpr_row_t    rows [7];
  assign cfg_seen = {6'h00, cycle_lengthen, 3'h0, ram_speed_select, clock_frequency_select, cycle_speed_select, port_sync, ecc};
  dpr_ctrl u_dpr_ctrl (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .refresh_request_input_in(refresh_in),
    .program_data_input_in(strap_en ? strap_lvl : sr_data), .port_req_in(port_req_in),
    .port_enable_n_in(port_en_n), .port_control_in(port_control_in), .cycle_done_in(done_in),
    .port_select_program_clock_out(pclk), .prog_done_out(prog_done), .ecc_mode_out(ecc),
    .port_sync_out(port_sync), .port_status_iface_out(port_iface),
    .cycle_speed_fast_out(cycle_speed_select), .clock_frequency_fast_out(clock_frequency_select), .ram_speed_fast_out(ram_speed_select),
    .cycle_lengthen_out(cycle_lengthen), .refresh_busy_out(busy), .cycle_start_out(start),
    .cycle_port_out(cycle_port), .scrub_out(scrub));
  dpr_bus_model u_dpr_bus_model (
    .mclk_in(mclk_in), .load_n_in(rstn_in), .shift_clk_in(pclk), .word_in(load_word),
    .cycle_start_in(start), .data_out(sr_data), .cycle_done_out(done_in));
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  always @(negedge mclk_in) begin
    pclk_prev <= pclk;
    if (!rstn_in) pclk_rises <= 0;
    else if (pclk && !pclk_prev && !prog_done) pclk_rises <= pclk_rises + 1;
    if (clr_cnt) begin
      ref_starts <= 0;
      scrubs <= 0;
    end else begin
      if (start === 1'b1 && cycle_port === 2'h2) ref_starts <= ref_starts + 1;
      if (start === 1'b1 && scrub === 1'b1) scrubs <= scrubs + 1;
    end
  end
  task automatic clear_counts();
    clr_cnt = 1'b1;
    @(posedge mclk_in);
    #2;
    clr_cnt = 1'b0;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic [15:0] word, input logic strap, input logic [1:0] port_control);
    int n;
    n = 0;
    rstn_in = 1'b0;
    load_word = word;
    strap_en = strap;
    strap_lvl = word[0];
    port_control_in = port_control;
    step(4);
    rstn_in = 1'b1;
    step(20);
    chk("early ecc", {15'h0, word[0]}, {15'h0, ecc});
    while (prog_done !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    step(2);
  endtask
  task automatic wait_start(output int lat);
    lat = 0;
    while (start !== 1'b1 && lat < 40) begin
      step(1);
      lat++;
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      step(1);
      n++;
    end
    step(20);
  endtask
  task automatic final_report();
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    fails++;
    final_report();
  end
  initial begin
    fails = 0;
    compares = 0;
    clr_cnt = 1'b0;
    port_en_n = 2'h0;
    rstn_in = 1'b0;
    refresh_in = 1'b0; // no refresh while held low
    port_req_in = 2'h0;
    rows[0] = '{1'b0, 16'h0001, 2'h1, 16'h0001};
    rows[1] = '{1'b0, 16'h0226, 2'h2, 16'h0226};
    rows[2] = '{1'b0, 16'h0438, 2'h3, 16'h0438};
    rows[3] = '{1'b0, 16'hFFFF, 2'h0, 16'h0013};
    rows[4] = '{1'b0, 16'h0000, 2'h1, 16'h0012};
    rows[5] = '{1'b1, 16'hFFFF, 2'h2, 16'h0013};
    rows[6] = '{1'b1, 16'h0000, 2'h0, 16'h0012};
    foreach (rows[i]) begin
      do_reset(rows[i].word, rows[i].use_strap, rows[i].port_control);
      chk("pclk pulses", 16'h0010, pclk_rises[15:0]);
      chk("config", rows[i].exp_word & 16'h023F, cfg_seen);
      chk("iface", {14'h0, rows[i].port_control}, {14'h0, port_iface});
    end
    // external single and burst refresh, ecc word
    do_reset(16'h0017, 1'b0, 2'h0);
    clear_counts();
    refresh_in = 1'b1;
    step(1);
    refresh_in = 1'b0;
    wait_idle();
    chk("single refresh", 16'h0001, ref_starts[15:0]);
    clear_counts();
    refresh_in = 1'b1;
    step(3);
    refresh_in = 1'b0;
    step(12);
    refresh_in = 1'b1;
    step(1);
    refresh_in = 1'b0;
    wait_idle();
    chk("burst rows", 16'h0080, ref_starts[15:0]);
    chk("scrub rows", 16'h0080, scrubs[15:0]);
    // arbitration, port a favoured
    port_req_in = 2'h3;
    wait_start(lat);
    chk("first port", 16'h0000, {14'h0, cycle_port});
    port_req_in = 2'h2;
    step(1);
    wait_start(lat);
    chk("second port", 16'h0001, {14'h0, cycle_port});
    port_req_in = 2'h0;
    step(8);
    port_req_in = 2'h2;
    wait_start(lat);
    port_req_in = 2'h0;
    step(8);
    port_req_in = 2'h1;
    wait_start(lat2);
    port_req_in = 2'h0;
    chk("selected fast", 16'h0001, {15'h0, lat <= 2});
    chk("switch delay", 16'h0001, {15'h0, lat2 >= 3 && lat2 <= 5 && lat2 > lat});
    chk("mux to a", 16'h0001, {15'h0, pclk});
    chk("config kept", 16'h0017, cfg_seen);
    // most recently used port stays selected
    do_reset(16'h0417, 1'b0, 2'h0);
    port_req_in = 2'h2;
    wait_start(lat);
    port_req_in = 2'h0;
    step(8);
    port_req_in = 2'h3;
    wait_start(lat);
    port_req_in = 2'h0;
    chk("sticky port", 16'h0001, {14'h0, cycle_port});
    step(8);
    // disabled port never starts
    port_en_n = 2'h2;
    port_req_in = 2'h2;
    wait_start(lat);
    chk("disabled port", 16'h0000, {15'h0, start});
    port_req_in = 2'h0;
    port_en_n = 2'h0;
    // failsafe: high through reset, rise restarts the interval
    refresh_in = 1'b1;
    do_reset(16'h0017, 1'b0, 2'h0);
    clear_counts();
    refresh_in = 1'b0;
    step(400);
    chk("fall ignored", 16'h0000, ref_starts[15:0]);
    refresh_in = 1'b1;
    step(500);
    chk("rise restart", 16'h0001, ref_starts[15:0]);
    step(200);
    chk("timer refresh", 16'h0002, ref_starts[15:0]);
    // short period, thirty percent off, slow clock: about 103 clocks apart
    do_reset(16'h01C1, 1'b0, 2'h0);
    clear_counts();
    step(399);
    chk("scaled interval", 16'h0003, ref_starts[15:0]);
    final_report();
  end
endmodule // dpr_ctrl_test
`default_nettype wire

/* design/dpr_ctrl.sv */
// Notes on behaviour
// [R1] refresh input low at reset: one-clock high pulse gives one refresh
// [R2] new external refresh ignored until previous request or burst is finished
// [R3] non-failsafe: input high two or more clocks gives 128-row burst
// [R4] in ecc mode every burst refresh cycle is a scrub cycle
// [R5] other party keeps refresh input low for no refresh at all
// [R6] sixteen-bit program word, first bit selects ecc mode
// [R7] exactly sixteen program clock pulses on the shared select pin
// [R8] after programming data input ignored, pin is only port select
// [R9] external shift register loads on reset and shifts on program clock
// [R10] data input level at reset steers ecc mode before programming ends
// [R11] strapped high gives default ecc word, low gives default non-ecc word
// [R12] per-port bit chooses synchronous or synchronised request inputs
// [R13] sync port takes status or command; async only command or gated status
// [R14] cycle-speed bit selects slow or fast processor signalling
// [R15] clock-frequency bit scales failsafe refresh interval
// [R16] ram-speed bit selects fast or slow ram timing
// [R17] refresh every 15.6 us, period bit makes it 7.8 us
// [R18] count-interval bits shorten interval by 0, 10, 20 or 30 percent
// [R19] interval counter counts clocks with about 5 percent margin
// [R20] lengthen bit lengthens each memory cycle
// [R21] three requesters: port a, port b, refresh port
// [R22] priority bit 1 keeps last port, 0 favours port a
// [R23] selected port starts at once, unselected port after select switch
// [R24] failsafe: rising edge requests refresh and restarts interval counter
// [R25] one data sample per program clock pulse, bit zero first
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defines.svh"
module dpr_ctrl (
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        refresh_request_input_in,
  input  wire logic        program_data_input_in,
  input  wire logic [1:0]  port_req_in,
  input  wire logic [1:0]  port_enable_n_in,
  input  wire logic [1:0]  port_control_in,
  input  wire logic        cycle_done_in,
  output logic             port_select_program_clock_out,
  output logic             prog_done_out,
  output logic             ecc_mode_out,
  output logic [1:0]       port_sync_out,
  output logic [1:0]       port_status_iface_out,
  output logic             cycle_speed_fast_out,
  output logic             clock_frequency_fast_out,
  output logic             ram_speed_fast_out,
  output logic             cycle_lengthen_out,
  output logic             refresh_busy_out,
  output logic             cycle_start_out,
  output logic [1:0]       cycle_port_out,
  output logic             scrub_out
);
  logic              rs1_q, rst_n;
  logic              rq1_q, rq_q, rq_d1_q, pd1_q, pd_q;
  logic              rel_q, ecc_strap_q, failsafe_q;
  dpr_pkg::dpr_prog_t prg_q;
  logic [1:0]        ph_q;
  logic [3:0]        bit_q;
  logic [15:0]       shf_q, cfg_q;
  logic              pclk_q;
  logic [1:0]        req_v, en_v, ctl_v, want;
  logic [7:0]        left_q;
  logic [1:0]        hi_q;
  logic              rise, fall, single_go, burst_go, tick, ref_set, ref_take;
  logic [`DPR_IVL_W-1:0] ivl;
  dpr_pkg::dpr_arb_t  arb_q;
  dpr_pkg::dpr_port_t sel_q, win;
  logic [1:0]        sw_q;
  logic              mux_q, start_q, scrub_q;
  logic [1:0]        cport_q;

  // reset release
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // pin synchronisers
  always_ff @(posedge mclk_in) begin
    rq1_q   <= refresh_request_input_in;
    rq_q    <= rq1_q;
    rq_d1_q <= rq_q;
    pd1_q   <= program_data_input_in;
    pd_q    <= pd1_q;
  end

  // strap capture at first edge after release
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rel_q       <= 1'b0;
      ecc_strap_q <= 1'b0;
      failsafe_q  <= 1'b0;
      port_status_iface_out <= 2'h0;
    end else if (!rel_q) begin
      rel_q       <= 1'b1;
      ecc_strap_q <= pd_q; // [R10]
      failsafe_q  <= rq_q; // [R24] [R1]
      port_status_iface_out <= ctl_v; // [R13]
    end
  end

  // serial programming
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      prg_q  <= dpr_pkg::PRG_LOW;
      ph_q   <= 2'h0;
      bit_q  <= 4'h0;
      shf_q  <= `DPR_WORD_ZEROS;
      cfg_q  <= `DPR_WORD_ZEROS;
      pclk_q <= 1'b0;
    end else if (rel_q) begin
      case (prg_q)
        dpr_pkg::PRG_LOW: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == `DPR_PCLK_HALF) begin
            shf_q  <= {pd_q, shf_q[15:1]}; // [R25]
            pclk_q <= 1'b1; // [R7] [R9]
            prg_q  <= dpr_pkg::PRG_HIGH;
          end
        end
        dpr_pkg::PRG_HIGH: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == `DPR_PCLK_HALF) begin
            pclk_q <= 1'b0;
            bit_q  <= bit_q + 4'h1;
            if (bit_q == `DPR_PROG_LAST) begin
              prg_q <= dpr_pkg::PRG_DONE; // [R7]
              if (shf_q == `DPR_WORD_ONES) begin
                cfg_q <= `DPR_DEF_ECC; // [R11]
              end else if (shf_q == `DPR_WORD_ZEROS) begin
                cfg_q <= `DPR_DEF_NON_ECC; // [R11]
              end else begin
                cfg_q <= shf_q; // [R6]
              end
            end else begin
              prg_q <= dpr_pkg::PRG_LOW;
            end
          end
        end
        default: begin
          prg_q <= dpr_pkg::PRG_DONE; // [R8]
        end
      endcase
    end
  end

  assign prog_done_out = (prg_q == dpr_pkg::PRG_DONE);
  assign ecc_mode_out  = prog_done_out ? cfg_q[`DPR_B_ECC] : ecc_strap_q; // [R10] [R6]
  assign port_sync_out = {cfg_q[`DPR_B_SB], cfg_q[`DPR_B_SA]};
  assign cycle_speed_fast_out     = cfg_q[`DPR_B_CFS]; // [R14]
  assign clock_frequency_fast_out = cfg_q[`DPR_B_FFS];
  assign ram_speed_fast_out       = cfg_q[`DPR_B_RFS]; // [R16]
  assign cycle_lengthen_out       = cfg_q[`DPR_B_EXT]; // [R20]
  assign port_select_program_clock_out = prog_done_out ? mux_q : pclk_q; // [R8]

  // port input synchronisers, chosen per port
  generate
    for (genvar gi = 0; gi < 2; gi++) begin : g_port
      logic [2:0] s1_q, s2_q;
      always_ff @(posedge mclk_in) begin
        s1_q <= {port_control_in[gi], port_enable_n_in[gi], port_req_in[gi]};
        s2_q <= s1_q;
      end
      assign req_v[gi] = port_sync_out[gi] ? port_req_in[gi] : s2_q[0]; // [R12]
      assign en_v[gi]  = port_sync_out[gi] ? !port_enable_n_in[gi] : !s2_q[1]; // [R12]
      assign ctl_v[gi] = port_sync_out[gi] ? port_control_in[gi] : s2_q[2]; // [R12]
      assign want[gi]  = prog_done_out && req_v[gi] && en_v[gi];
    end
  endgenerate

  // refresh interval from config
  function automatic logic [`DPR_IVL_W-1:0] ivl_f(input logic refresh_period_long_short, input logic [1:0] ci,
                                                 input logic clock_frequency_select);
    int c;
    c = refresh_period_long_short ? `DPR_SHORT_CYC : `DPR_LONG_CYC; // [R17] [R19]
    c = (c * (100 - `DPR_CI_STEP_PCT * int'(ci))) / 100; // [R18]
    if (!clock_frequency_select) begin
      c = c / 2; // [R15]
    end
    return c[`DPR_IVL_W-1:0];
  endfunction

  assign ivl = ivl_f(cfg_q[`DPR_B_PLS], {cfg_q[`DPR_B_CI1], cfg_q[`DPR_B_CI0]},
                     cfg_q[`DPR_B_FFS]);

  assign rise = prog_done_out && rq_q && !rq_d1_q;
  assign fall = !rq_q && rq_d1_q;

  dpr_interval_timer u_timer (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n),
    .run_in      (prog_done_out && failsafe_q),
    .restart_in  (rise && failsafe_q), // [R24]
    .interval_in (ivl),
    .tick_out    (tick)
  );

  // non-failsafe pulse width decode
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= 2'h0;
    end else if (failsafe_q || !rq_q) begin
      hi_q <= 2'h0;
    end else if (rise && left_q == 8'h00) begin
      hi_q <= 2'h1; // [R2]
    end else if (hi_q == 2'h1) begin
      hi_q <= 2'h2;
    end
  end

  assign single_go = !failsafe_q && fall && hi_q == 2'h1; // [R1]
  assign burst_go  = !failsafe_q && rq_q && hi_q == 2'h1; // [R3]
  assign ref_set   = failsafe_q && (rise || tick); // [R24]
  assign ref_take  = start_q && cport_q == 2'(dpr_pkg::PORT_C);

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 8'h00;
    end else if (left_q != 8'h00) begin
      if (ref_take) begin
        left_q <= left_q - 8'h01; // [R2]
      end
    end else if (burst_go) begin
      left_q <= `DPR_BURST_ROWS; // [R3]
    end else if (single_go || ref_set) begin
      left_q <= `DPR_ONE_ROW; // [R1] [R24]
    end
  end

  assign refresh_busy_out = (left_q != 8'h00);

  // arbitration winner
  always_comb begin
    win = sel_q;
    if (refresh_busy_out && !ref_take) begin
      win = dpr_pkg::PORT_C; // [R21]
    end else if (cfg_q[`DPR_B_PPR] && sel_q == dpr_pkg::PORT_B && want[1]) begin
      win = dpr_pkg::PORT_B; // [R22]
    end else if (cfg_q[`DPR_B_PPR] && sel_q == dpr_pkg::PORT_A && want[0]) begin
      win = dpr_pkg::PORT_A; // [R22]
    end else if (want[0]) begin
      win = dpr_pkg::PORT_A; // [R22]
    end else if (want[1]) begin
      win = dpr_pkg::PORT_B;
    end
  end

  wire win_req = (win == dpr_pkg::PORT_C) ? refresh_busy_out && !ref_take :
                 (win == dpr_pkg::PORT_A) ? want[0] : want[1];

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      arb_q   <= dpr_pkg::ARB_IDLE;
      sel_q   <= dpr_pkg::PORT_A;
      sw_q    <= 2'h0;
      mux_q   <= 1'b1;
      start_q <= 1'b0;
      cport_q <= 2'h0;
      scrub_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (arb_q)
        dpr_pkg::ARB_IDLE: begin
          if (win_req && win == sel_q) begin
            start_q <= 1'b1; // [R23]
            cport_q <= 2'(win);
            scrub_q <= (win == dpr_pkg::PORT_C) && ecc_mode_out; // [R4]
            arb_q   <= dpr_pkg::ARB_BUSY;
          end else if (win_req) begin
            sel_q <= win; // [R23]
            if (win != dpr_pkg::PORT_C) begin
              mux_q <= (win == dpr_pkg::PORT_A);
            end
            sw_q  <= 2'h0;
            arb_q <= dpr_pkg::ARB_SWITCH;
          end
        end
        dpr_pkg::ARB_SWITCH: begin
          sw_q <= sw_q + 2'h1;
          if (sw_q == `DPR_SWITCH_LAST) begin
            if (win_req && win == sel_q) begin
              start_q <= 1'b1; // [R23]
              cport_q <= 2'(sel_q);
              scrub_q <= (sel_q == dpr_pkg::PORT_C) && ecc_mode_out; // [R4]
              arb_q   <= dpr_pkg::ARB_BUSY;
            end else begin
              arb_q <= dpr_pkg::ARB_IDLE;
            end
          end
        end
        default: begin
          if (cycle_done_in) begin
            arb_q <= dpr_pkg::ARB_IDLE;
          end
        end
      endcase
    end
  end

  assign cycle_start_out = start_q;
  assign cycle_port_out  = cport_q;
  assign scrub_out       = scrub_q;

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  logic [4:0] pulses_q;
  logic       pclk_d_q;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      pulses_q <= 5'h00;
      pclk_d_q <= 1'b0;
    end else begin
      pclk_d_q <= pclk_q;
      if (!prog_done_out && pclk_q && !pclk_d_q) begin
        pulses_q <= pulses_q + 5'h01;
      end
    end
  end

  sequence s_one_high;
    !failsafe_q && prog_done_out && !refresh_busy_out && rise ##1 fall;
  endsequence

  a_prog_pulses: assert property (prog_done_out |-> pulses_q == 5'h10) // [R7]
    else $error("program clock pulse count is not sixteen");
  a_pin_is_mux: assert property (prog_done_out |-> port_select_program_clock_out == mux_q) // [R8]
    else $error("shared pin not acting as port select");
  a_ecc_follows: assert property ($rose(prog_done_out) // [R6]
      |-> ecc_mode_out == cfg_q[`DPR_B_ECC])
    else $error("ecc mode not taken from program word");
  a_single_req: assert property (s_one_high |=> left_q == `DPR_ONE_ROW) // [R1]
    else $error("single pulse did not queue one refresh");
  a_burst_req: assert property (!failsafe_q && prog_done_out && !refresh_busy_out // [R3]
      && rise ##1 rq_q |=> left_q == `DPR_BURST_ROWS)
    else $error("long pulse did not queue a burst");
  a_busy_ignore: assert property (refresh_busy_out && !ref_take // [R2]
      |=> left_q == $past(left_q))
    else $error("refresh count changed while busy");
  a_fs_edge: assert property (failsafe_q && rise && !refresh_busy_out // [R24]
      |=> refresh_busy_out)
    else $error("failsafe edge raised no request");
  a_switch_delay: assert property (arb_q == dpr_pkg::ARB_IDLE && win_req && win != sel_q // [R23]
      |-> !start_q ##1 !start_q ##1 !start_q)
    else $error("unselected port started too early");
  a_scrub_ecc: assert property (start_q && cport_q == 2'(dpr_pkg::PORT_C) // [R4]
      |-> scrub_q == ecc_mode_out)
    else $error("refresh cycle scrub flag wrong");
  a_ppr_stay: assert property (arb_q == dpr_pkg::ARB_IDLE && cfg_q[`DPR_B_PPR] // [R22]
      && !refresh_busy_out && sel_q == dpr_pkg::PORT_B && want[1]
      |=> start_q && cport_q == 2'(dpr_pkg::PORT_B))
    else $error("most recent port not kept");
endmodule // dpr_ctrl
`default_nettype wire

/* design/dpr_defines.svh */
`ifndef DPR_DEFINES_SVH
`define DPR_DEFINES_SVH

// program word layout
`define DPR_PROG_LAST      4'hF
`define DPR_B_ECC          0
`define DPR_B_SA           1
`define DPR_B_SB           2
`define DPR_B_CFS          3
`define DPR_B_FFS          4
`define DPR_B_RFS          5
`define DPR_B_CI0          6
`define DPR_B_CI1          7
`define DPR_B_PLS          8
`define DPR_B_EXT          9
`define DPR_B_PPR          10
`define DPR_WORD_ONES      16'hFFFF
`define DPR_WORD_ZEROS     16'h0000
`define DPR_DEF_NON_ECC    16'h0012
`define DPR_DEF_ECC        16'h0013

// program clock phase length
`define DPR_PCLK_HALF      2'h3

// refresh and port switch
`define DPR_BURST_ROWS     8'h80
`define DPR_ONE_ROW        8'h01
`define DPR_SWITCH_LAST    2'h1
`define DPR_CLK_NS         25
`define DPR_PERIOD_LONG_NS 15600
`define DPR_PERIOD_SHORT_NS 7800
`define DPR_MARGIN_PCT     95
`define DPR_CI_STEP_PCT    10
`define DPR_LONG_CYC  ((`DPR_PERIOD_LONG_NS * `DPR_MARGIN_PCT) / (100 * `DPR_CLK_NS))
`define DPR_SHORT_CYC ((`DPR_PERIOD_SHORT_NS * `DPR_MARGIN_PCT) / (100 * `DPR_CLK_NS))
`define DPR_IVL_W          11

`endif

/* design/dpr_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defines.svh"
module dpr_interval_timer (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   run_in,
  input  wire logic                   restart_in,
  input  wire logic [`DPR_IVL_W-1:0]  interval_in,
  output logic                        tick_out
);
  logic [`DPR_IVL_W-1:0] cnt_q;

  // counts clock periods, reloads on restart or expiry
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= {`DPR_IVL_W{1'b0}};
    end else if (!run_in || restart_in || tick_out) begin
      cnt_q <= {`DPR_IVL_W{1'b0}};
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick_out = run_in && !restart_in && (cnt_q == interval_in - 1'b1);
endmodule // dpr_interval_timer
`default_nettype wire

/* design/dpr_pkg.sv */
package dpr_pkg;
  typedef enum logic [1:0] {PRG_LOW, PRG_HIGH, PRG_DONE} dpr_prog_t;
  typedef enum logic [1:0] {ARB_IDLE, ARB_SWITCH, ARB_BUSY} dpr_arb_t;
  typedef enum logic [1:0] {PORT_A, PORT_B, PORT_C} dpr_port_t;
endpackage
